/* contact_eval_pkg.sv */
// constants shared by the safety contact evaluator files
package contact_eval_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] FILTER_ADDR = 8'h04;
  localparam logic [7:0] SIMUL_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_KIND_LSB = 1;
  localparam int CTRL_WIRING_LSB = 3;
  localparam int CTRL_RESET_EN_BIT = 5;
  localparam int CTRL_MONITORED_BIT = 6;
  localparam int CTRL_TEST_EN_BIT = 7;
  localparam int CTRL_STARTUP_BIT = 8;
  localparam int CTRL_SIMUL_EN_BIT = 9;
  localparam int CTRL_ERROR_EN_BIT = 10;
  localparam int CTRL_CLEAR_BIT = 11;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status register fields
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_SIMUL_BIT = 2;
  localparam int STAT_MISMATCH_BIT = 3;
  localparam int STAT_SHORT_BIT = 4;
  localparam int STAT_PENDING_BIT = 5;
  localparam int STAT_CH_LSB = 6;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US;
  localparam logic [7:0] FILTER_MIN_MS = 8'h03;
  localparam logic [7:0] FILTER_MAX_MS = 8'hfa;
  localparam logic [7:0] FILTER_RESET_MS = 8'h03;
  localparam logic [15:0] SIMUL_RESET_MS = 16'h0064;
  // test pulse: low phase length and settle before sampling, in cycles
  localparam int PULSE_CYCLES = 64;
  localparam int PULSE_PERIOD_CYCLES = 100_000;

  // ---------------------------------------------------------------
  // device kinds and wirings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_STOP = 2'b00,
    KIND_GUARD = 2'b01,
    KIND_GUARD_SINGLE = 2'b10,
    KIND_LOCK = 2'b11
  } kind_e;

  typedef enum logic [1:0] {
    WIRE_SINGLE_NC = 2'b00,
    WIRE_DOUBLE_NC = 2'b01,
    WIRE_NO_NC = 2'b10
  } wiring_e;

endpackage : contact_eval_pkg

/* contact_debounce.sv */
// one debounce filter for a single contact line
`timescale 1ns/1ps
module contact_debounce #(
  parameter int LEN_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [LEN_W-1:0] length_ms,
  input wire logic raw,
  output logic filtered
);

  // ---------------------------------------------------------------
  // filter state
  // ---------------------------------------------------------------
  logic [LEN_W-1:0] stable_ms;
  wire differs = raw != filtered;
  wire expired = tick && (stable_ms + 1'b1 >= length_ms);

  // a change must hold for the whole length before it passes, so bounce is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_ms <= '0;
      filtered <= 1'b0;
    end else if (!differs) begin
      stable_ms <= '0;
    end else if (expired) begin
      stable_ms <= '0;
      filtered <= raw;
    end else if (tick) begin
      stable_ms <= stable_ms + 1'b1;
    end
  end

endmodule : contact_debounce

/* reset_detect.sv */
// reset pushbutton sequence detector, manual and monitored forms
`timescale 1ns/1ps
module reset_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic monitored,
  input wire logic button,
  output logic accepted
);

  // ---------------------------------------------------------------
  // edge tracking
  // ---------------------------------------------------------------
  logic button_q;
  logic armed;
  wire rise = button && !button_q;
  wire fall = !button && button_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      button_q <= 1'b0;
      armed <= 1'b0;
    end else begin
      button_q <= button;
      if (rise) begin
        armed <= 1'b1;
      end else if (fall) begin
        armed <= 1'b0;
      end
    end
  end

  // manual takes the rising edge; monitored waits for the return to 0
  assign accepted = monitored ? (fall && armed) : rise;

endmodule : reset_detect

/* safety_contact_input_evaluator.sv */
// safety contact input evaluator with apb register access
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module safety_contact_input_evaluator #(
  parameter int TICK_CYCLES = contact_eval_pkg::TICK_CYCLES,
  parameter int PULSE_PERIOD = contact_eval_pkg::PULSE_PERIOD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic contact_input_first,
  input wire logic contact_input_second,
  input wire logic reset_button,
  output logic test_drive_first,
  output logic test_drive_second,
  output logic evaluated_out,
  output logic fault_flag
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (TICK_CYCLES < 2 || PULSE_PERIOD <= 2 * contact_eval_pkg::PULSE_CYCLES) begin : g_bad
    $error("tick or test pulse period too small");
  end

  // ---------------------------------------------------------------
  // apb slave and registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic [7:0] filter_ms;
  logic [15:0] simul_ms;
  wire wr_en = psel && penable && pwrite;
  wire hit_ctrl = paddr == contact_eval_pkg::CTRL_ADDR;
  wire hit_filter = paddr == contact_eval_pkg::FILTER_ADDR;
  wire hit_simul = paddr == contact_eval_pkg::SIMUL_ADDR;
  wire hit_status = paddr == contact_eval_pkg::STATUS_ADDR;
  wire mapped = hit_ctrl || hit_filter || hit_simul || hit_status;
  wire [7:0] filter_wr = pwdata[7:0];
  wire filter_ok = filter_wr >= contact_eval_pkg::FILTER_MIN_MS &&
                   filter_wr <= contact_eval_pkg::FILTER_MAX_MS;
  wire clear_req = wr_en && hit_ctrl && pwdata[contact_eval_pkg::CTRL_CLEAR_BIT];

  // zero-wait slave; out-of-range filter lengths and unmapped addresses give pslverr
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && hit_filter && !filter_ok));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= contact_eval_pkg::CTRL_RESET;
      filter_ms <= contact_eval_pkg::FILTER_RESET_MS;
      simul_ms <= contact_eval_pkg::SIMUL_RESET_MS;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl <= {21'h00_0000, pwdata[10:0]}; // clear strobe is never stored
      if (hit_filter && filter_ok) filter_ms <= filter_wr;
      if (hit_simul) simul_ms <= pwdata[15:0];
    end
  end

  // control fields
  wire enable = ctrl[contact_eval_pkg::CTRL_ENABLE_BIT];
  contact_eval_pkg::kind_e kind;
  contact_eval_pkg::wiring_e wiring;
  assign kind = contact_eval_pkg::kind_e'(ctrl[contact_eval_pkg::CTRL_KIND_LSB +: 2]);
  assign wiring = contact_eval_pkg::wiring_e'(ctrl[contact_eval_pkg::CTRL_WIRING_LSB +: 2]);
  wire reset_en = ctrl[contact_eval_pkg::CTRL_RESET_EN_BIT];
  wire monitored = ctrl[contact_eval_pkg::CTRL_MONITORED_BIT];
  wire test_en = ctrl[contact_eval_pkg::CTRL_TEST_EN_BIT];
  wire startup_en = ctrl[contact_eval_pkg::CTRL_STARTUP_BIT];
  wire simul_en = ctrl[contact_eval_pkg::CTRL_SIMUL_EN_BIT];
  wire error_en = ctrl[contact_eval_pkg::CTRL_ERROR_EN_BIT];

  // ---------------------------------------------------------------
  // millisecond tick
  // ---------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYCLES);
  logic [TW-1:0] tick_cnt;
  wire tick = tick_cnt == TW'(TICK_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt <= '0;
    else tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
  end

  // ---------------------------------------------------------------
  // test pulse generator
  // ---------------------------------------------------------------
  // each line is pulled low in its own slot; a line that follows the other's
  // pulse is shorted to it. contacts are assumed closed while sampled.
  localparam int PW = $clog2(PULSE_PERIOD);
  logic [PW-1:0] pulse_cnt;
  wire slot_first = pulse_cnt < PW'(contact_eval_pkg::PULSE_CYCLES);
  wire slot_second = pulse_cnt >= PW'(contact_eval_pkg::PULSE_CYCLES) &&
                     pulse_cnt < PW'(2 * contact_eval_pkg::PULSE_CYCLES);
  wire sample_first = pulse_cnt == PW'(contact_eval_pkg::PULSE_CYCLES - 1);
  wire sample_second = pulse_cnt == PW'(2 * contact_eval_pkg::PULSE_CYCLES - 1);
  wire in_slot = slot_first || slot_second;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pulse_cnt <= '0;
    else pulse_cnt <= (pulse_cnt == PW'(PULSE_PERIOD - 1)) ? '0 : pulse_cnt + 1'b1;
  end

  // drive high except in the line's own low slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_drive_first <= 1'b1;
      test_drive_second <= 1'b1;
    end else begin
      test_drive_first <= !(test_en && slot_first);
      test_drive_second <= !(test_en && slot_second);
    end
  end

  wire two_ch = wiring != contact_eval_pkg::WIRE_SINGLE_NC &&
                kind != contact_eval_pkg::KIND_GUARD_SINGLE;

  // ---------------------------------------------------------------
  // debounce filters, held during test slots
  // ---------------------------------------------------------------
  logic [1:0] filt;
  logic [1:0] raw_q;
  wire [1:0] raw_in = {contact_input_second, contact_input_first};

  // freeze the raw view while a test pulse is on the lines; the drives lag the
  // slot by one cycle, so a drive still low freezes it as well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) raw_q <= 2'b00;
    else if (!(test_en && in_slot) && test_drive_first && test_drive_second) raw_q <= raw_in;
  end

  // a line high before the slot that drops in the other line's slot is joined
  // to it; an open contact reads low anyway and is not taken for a short
  wire short_seen = test_en && two_ch &&
                    ((sample_first && raw_q[1] && !contact_input_second) ||
                     (sample_second && raw_q[0] && !contact_input_first));

  for (genvar i = 0; i < 2; i++) begin : g_filt
    contact_debounce #(.LEN_W(8)) u_deb (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .length_ms(filter_ms),
      .raw(raw_q[i]),
      .filtered(filt[i])
    );
  end

  // ---------------------------------------------------------------
  // channel evaluation
  // ---------------------------------------------------------------
  // active means closed guard, released button or locked guard; mixed wiring on a
  // guard or lock expects the first (open) contact closed and the second open when active
  logic ch_a;
  logic ch_b;
  always_comb begin
    ch_a = filt[0];
    ch_b = filt[1];
    if (wiring == contact_eval_pkg::WIRE_NO_NC && kind != contact_eval_pkg::KIND_STOP) begin
      ch_b = !filt[1];
    end
  end

  // filters leave reset at 0, which reads as a pressed button: no start-up or
  // skew decision until one full filter length has passed
  logic [7:0] settle_ms;
  wire settled = settle_ms > filter_ms;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) settle_ms <= '0;
    else if (tick && settle_ms != 8'hff) settle_ms <= settle_ms + 1'b1;
  end

  wire single = !two_ch;
  wire both_safe = single ? ch_a : (ch_a && ch_b);
  wire both_off = single ? !ch_a : (!ch_a && !ch_b);
  wire disagree = settled && !single && (ch_a != ch_b);

  // simultaneity timer in ms while channels disagree
  logic [15:0] skew_ms;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) skew_ms <= '0;
    else if (!disagree) skew_ms <= '0;
    else if (tick && skew_ms != 16'hffff) skew_ms <= skew_ms + 1'b1;
  end

  // no limit on single channel guards, they have no partner line
  wire simul_fault = simul_en && kind != contact_eval_pkg::KIND_GUARD_SINGLE &&
                     disagree && skew_ms >= simul_ms;
  // without the window, a disagreement is a mismatch once the filter has run out twice
  wire mismatch_fault = !simul_en && disagree &&
                        skew_ms >= {7'h00, filter_ms, 1'b0};

  // ---------------------------------------------------------------
  // fault latches
  // ---------------------------------------------------------------
  logic f_simul;
  logic f_mismatch;
  logic f_short;
  wire any_fault = f_simul || f_mismatch || f_short;

  // a new fault in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_simul <= 1'b0;
      f_mismatch <= 1'b0;
      f_short <= 1'b0;
    end else if (enable) begin
      f_simul <= simul_fault || (f_simul && !clear_req);
      f_mismatch <= mismatch_fault || (f_mismatch && !clear_req);
      f_short <= short_seen || (f_short && !clear_req);
    end
  end

  // ---------------------------------------------------------------
  // output state: start-up test, reset latch
  // ---------------------------------------------------------------
  logic reset_ok;
  reset_detect u_rst (
    .pclk(pclk),
    .presetn(presetn),
    .monitored(monitored),
    .button(reset_button),
    .accepted(reset_ok)
  );

  logic startup_done;
  logic startup_seen_off;
  logic latched;
  logic armed_safe;

  // start-up test: stop needs off then safe, guard needs one opening
  wire startup_pass = kind == contact_eval_pkg::KIND_STOP ? (startup_seen_off && both_safe)
                                                          : startup_seen_off;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_done <= 1'b0;
      startup_seen_off <= 1'b0;
    end else if (enable && settled && !startup_done) begin
      if (both_off) startup_seen_off <= 1'b1;
      if (startup_pass || kind == contact_eval_pkg::KIND_LOCK) startup_done <= 1'b1;
    end
  end

  // each activation latches low; reset counts only once the input is safe again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched <= 1'b1;
      armed_safe <= 1'b0;
    end else if (!both_safe || any_fault) begin
      latched <= 1'b1;
      armed_safe <= 1'b0;
    end else if (!armed_safe) begin
      armed_safe <= 1'b1;
    end else if (reset_ok) begin
      latched <= 1'b0;
    end
  end

  wire use_reset = reset_en && kind != contact_eval_pkg::KIND_LOCK;
  wire startup_block = startup_en && kind != contact_eval_pkg::KIND_LOCK && !startup_done;
  wire next_out = enable && both_safe && !any_fault && !startup_block &&
                  !(use_reset && latched);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evaluated_out <= 1'b0;
      fault_flag <= 1'b0;
    end else begin
      evaluated_out <= next_out;
      fault_flag <= error_en && any_fault;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [31:0] status_word = {24'h000000, filt, startup_block, f_short, f_mismatch,
                             f_simul, fault_flag, evaluated_out};
  wire [31:0] read_mux = hit_ctrl ? ctrl :
                         hit_filter ? {24'h000000, filter_ms} :
                         hit_simul ? {16'h0000, simul_ms} :
                         hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= read_mux;
  end

endmodule : safety_contact_input_evaluator

/* contact_eval_monitor.sv */
// port-level assertions for the safety contact evaluator
`timescale 1ns/1ps
module contact_eval_monitor #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic contact_input_first,
  input wire logic test_drive_first,
  input wire logic test_drive_second,
  input wire logic evaluated_out,
  input wire logic fault_flag
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  // limit covers the longest filter plus tick phase and registers
  localparam int OPEN_LIMIT = 252 * TICK_CYCLES;
  logic [31:0] open_run;
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};

  // run length of an open first line, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_run <= '0;
    end else if (contact_input_first) begin
      open_run <= '0;
    end else if (open_run <= OPEN_LIMIT) begin
      open_run <= open_run + 32'h1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access without error");
  unmapped_zero_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  filter_range_a: assert property (psel && penable && pwrite &&
    paddr == 8'h04 && (pwdata[7:0] < 8'h03 || pwdata[7:0] > 8'hfa) |-> pslverr)
    else $error("filter length out of range accepted");
  drive_excl_a: assert property (!test_drive_first |-> test_drive_second)
    else $error("both test drives low");
  slot_length_a: assert property ($fell(test_drive_first) |->
    ##64 (test_drive_first && !test_drive_second))
    else $error("test slot length wrong");
  open_low_a: assert property (open_run > OPEN_LIMIT |-> !evaluated_out)
    else $error("output high with first line open");
  hold_filter_a: assert property (evaluated_out && test_drive_first &&
    $fell(contact_input_first) |-> ##20 evaluated_out)
    else $error("output fell faster than filter");
  fault_low_a: assert property ($rose(fault_flag) |-> ##2 !evaluated_out)
    else $error("fault without output low");
endmodule : contact_eval_monitor

bind safety_contact_input_evaluator contact_eval_monitor #(.TICK_CYCLES(TICK_CYCLES)) monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .contact_input_first(contact_input_first), .test_drive_first(test_drive_first),
  .test_drive_second(test_drive_second), .evaluated_out(evaluated_out),
  .fault_flag(fault_flag)
);

/* contact_device.sv */
// behavioural safety contacts and reset pushbutton on the far side
`timescale 1ns/1ps
module contact_device (
  input wire logic test_drive_first,
  input wire logic test_drive_second,
  input wire logic closed_a,
  input wire logic closed_b,
  input wire logic shorted,
  input wire logic button,
  output logic contact_input_first,
  output logic contact_input_second,
  output logic reset_button
);
  // a closed contact returns its test signal, an open one reads the input's pull-down;
  // a short joins both lines so either test slot pulls both low
  assign contact_input_first = shorted ? (test_drive_first & test_drive_second) :
    (closed_a & test_drive_first);
  assign contact_input_second = shorted ? (test_drive_first & test_drive_second) :
    (closed_b & test_drive_second);
  assign reset_button = button;
endmodule : contact_device

/* tb_safety_contact_input_evaluator.sv */
// self-checking bench for the safety contact evaluator
`timescale 1ns/1ps
module tb_safety_contact_input_evaluator;
  typedef struct {logic [31:0] data; logic [31:0] mask;} note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic line_a, line_b, rbtn, tdf, tds, out, flag;
  logic closed_a, closed_b, shorted, button;
  note_s rq[$];
  note_s nt;
  int fail_count, comparisons, f, n;
  // kind, wiring, safe pattern of the two lines; open is the inverse
  logic [5:0] tab [6] = '{6'h03, 6'h07, 6'h17, 6'h1a, 6'h23, 6'h3a};

  safety_contact_input_evaluator #(.TICK_CYCLES(10), .PULSE_PERIOD(200))
    safety_contact_input_evaluator_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contact_input_first(line_a), .contact_input_second(line_b), .reset_button(rbtn),
    .test_drive_first(tdf), .test_drive_second(tds), .evaluated_out(out),
    .fault_flag(flag));
  contact_device contact_device_i (
    .test_drive_first(tdf), .test_drive_second(tds), .closed_a(closed_a),
    .closed_b(closed_b), .shorted(shorted), .button(button),
    .contact_input_first(line_a), .contact_input_second(line_b), .reset_button(rbtn));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // reads note their expectation; the watcher below compares
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int k;
    if (!w) rq.push_back('{d, m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      final_report();
    end
    check("pslverr", {31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // read data taken at the edge where ready is sampled
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready && rq.size() > 0) begin
      nt = rq.pop_front();
      check("prdata", prdata & nt.mask, nt.data & nt.mask);
    end
  end

  task automatic chk_out(input logic v);
    check("evaluated_out", {31'h0, out}, {31'h0, v});
  endtask : chk_out

  task automatic wait_out(input logic v, input int lim);
    int k;
    k = 0;
    while (out !== v && k < lim) begin
      @(posedge pclk);
      k++;
    end
    chk_out(v);
    if (out !== v) final_report();
  endtask : wait_out

  task automatic restart;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : restart

  task automatic place(input logic [1:0] p);
    closed_a <= p[1];
    closed_b <= p[0];
  endtask : place

  task automatic push(input logic v);
    button <= v;
    repeat (60) @(posedge pclk);
  endtask : push

  // enable plus kind and wiring fields, then option bits
  function automatic logic [31:0] ctl(input logic [5:0] t, input logic [31:0] o);
    return {27'h0, t[3:2], t[5:4], 1'b1} | o;
  endfunction : ctl

  initial begin
    {psel, penable, pwrite, presetn, button, shorted} = 6'h0;
    {closed_a, closed_b} = 2'b11;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(32'h9fe7));
    restart();
    // register reset values, unmapped place, filter range
    apb(0, 8'h00, 32'h0, '1, 0);
    apb(0, 8'h04, 32'h3, 32'hff, 0);
    apb(0, 8'h08, 32'h64, 32'hffff, 0);
    apb(0, 8'h10, 32'h0, '1, 1);
    apb(1, 8'h04, 32'h2, 0, 1);
    apb(1, 8'h04, 32'hfb, 0, 1);
    apb(1, 8'h04, 32'hfa, 0, 0);
    apb(0, 8'h04, 32'hfa, 32'hff, 0);
    $display("test registers done");
    // every kind and wiring: tracking, bounce, filter delay
    for (int i = 0; i < 6; i++) begin
      f = $urandom_range(3, 6);
      restart();
      place(tab[i][1:0]);
      apb(1, 8'h04, f, 0, 0);
      apb(1, 8'h00, ctl(tab[i], 0), 0, 0);
      wait_out(1, 300);
      repeat (4) begin
        place(~tab[i][1:0]);
        repeat ($urandom_range(1, 15)) @(posedge pclk);
        place(tab[i][1:0]);
        repeat ($urandom_range(1, 40)) @(posedge pclk);
      end
      chk_out(1);
      place(~tab[i][1:0]);
      repeat (f * 10 - 12) @(posedge pclk);
      chk_out(1);
      wait_out(0, 40);
      place(tab[i][1:0]);
      wait_out(1, 100);
      $display("test kind %0d done", i);
    end
    // manual and monitored reset; a reset given while open is refused
    for (int m = 0; m < 2; m++) begin
      restart();
      apb(1, 8'h00, ctl(6'h07, 32'h20 | (m << 6)), 0, 0);
      place(2'b00);
      push(1);
      push(0);
      place(2'b11);
      repeat (100) @(posedge pclk);
      chk_out(0);
      push(1);
      chk_out(m == 0);
      push(0);
      chk_out(1);
      place(2'b00);
      repeat (2600) @(posedge pclk);
      place(2'b11);
      repeat (100) @(posedge pclk);
      chk_out(0);
      $display("test reset mode %0d done", m);
    end
    // start-up test on stop and on guard
    for (int i = 1; i < 4; i += 2) begin
      restart();
      place(tab[i][1:0]);
      apb(1, 8'h00, ctl(tab[i], 32'h100), 0, 0);
      repeat (200) @(posedge pclk);
      chk_out(0);
      place(~tab[i][1:0]);
      repeat (100) @(posedge pclk);
      place(tab[i][1:0]);
      wait_out(1, 200);
    end
    $display("test start-up done");
    // simultaneity window kept, then broken, then faults cleared
    restart();
    place(2'b11);
    apb(1, 8'h08, 32'h2, 0, 0);
    apb(1, 8'h00, ctl(6'h07, 32'h600), 0, 0);
    wait_out(1, 100);
    closed_a <= 1'b0;
    repeat (5) @(posedge pclk);
    closed_b <= 1'b0;
    wait_out(0, 100);
    place(2'b11);
    wait_out(1, 100);
    closed_a <= 1'b0;
    repeat (100) @(posedge pclk);
    check("fault_flag", {31'h0, flag}, 32'h1);
    apb(0, 8'h0c, 32'h6, 32'h7, 0);
    place(2'b11);
    repeat (60) @(posedge pclk);
    apb(1, 8'h00, ctl(6'h07, 32'he00), 0, 0);
    @(posedge pclk); // flag follows the cleared latch one register later
    check("fault_flag", {31'h0, flag}, 32'h0);
    $display("test simultaneity done");
    // test pulses on both lines, then a short between them
    restart();
    apb(1, 8'h00, ctl(6'h07, 32'h480), 0, 0);
    wait_out(1, 300);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      n = n + (tdf ? 0 : 1) + (tds ? 0 : 1);
    end
    check("test low cycles", n, 32'h80);
    // join the lines outside both slots, so neither line changes level at the moment the short is made
    n = 0;
    while (!(tdf && tds) && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check("slot gap", {31'h0, tdf && tds}, 32'h1);
    shorted <= 1'b1;
    repeat (400) @(posedge pclk);
    chk_out(0);
    apb(0, 8'h0c, 32'h12, 32'h13, 0);
    $display("test short done");
    final_report();
  end
endmodule : tb_safety_contact_input_evaluator
